//--- common/timer8_pkg.sv
package timer8_pkg;
	// register byte addresses: printed offsets are not all multiples of four, so index * 4
	localparam logic [7:0] IDX_COUNTER   = 8'h32;
	localparam logic [7:0] IDX_CONTROL_B = 8'h33;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h39;
	localparam logic [7:0] IDX_CONTROL_A = 8'h30;
	localparam logic [7:0] IDX_COMPARE_A = 8'h36;
	localparam logic [7:0] IDX_COMPARE_B = 8'h3C;
	localparam logic [7:0] IDX_IRQ_FLAGS = 8'h38;
	localparam int ADDR_W = 10;

	// control b fields
	localparam int CB_FORCE_A = 7;
	localparam int CB_FORCE_B = 6;
	localparam int CB_WAVE_HI = 3;
	// control a fields
	localparam int CA_OUT_A_LO = 6;
	localparam int CA_OUT_B_LO = 4;
	// mask / flag bits
	localparam int BIT_MATCH_B  = 2;
	localparam int BIT_MATCH_A  = 1;
	localparam int BIT_OVERFLOW = 0;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] COUNT_MAX  = 8'hFF;
	localparam logic [7:0] COUNT_BOT  = 8'h00;
	localparam logic [9:0] PRESCALE_WRAP = 10'h3FF;

	typedef enum logic [2:0] {
		CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
	} clock_sel_t;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- dv/core_model.sv
`timescale 1ns/1ns
`default_nettype none
// stands in for the processor core: takes each pending vector once, one ack pulse per entry
module core_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic auto_ack,
	input  wire logic irq_match_a,
	input  wire logic irq_match_b,
	input  wire logic irq_overflow,
	output logic      ack_match_a,
	output logic      ack_match_b,
	output logic      ack_overflow
);
	// the pulse drops for a cycle so a flag set again right away is seen as a new request
	always_ff @(posedge aclk) begin
		ack_match_a  <= aresetn && auto_ack && irq_match_a && !ack_match_a;
		ack_match_b  <= aresetn && auto_ack && irq_match_b && !ack_match_b;
		ack_overflow <= aresetn && auto_ack && irq_overflow && !ack_overflow;
	end
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import timer8_pkg::*;
	logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic        pin = 0, gie = 0, auto_ack = 0;
	logic [9:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        ia, ib, io, aa, ab, ao, oa, ob, ea, eb;
	int          miscompares = 0, checked = 0;
	always #2 aclk = ~aclk;
	timer8_control_and_flags dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .external_count_pin(pin),
		.global_irq_enable(gie), .ack_match_a(aa), .ack_match_b(ab), .ack_overflow(ao),
		.irq_match_a(ia), .irq_match_b(ib), .irq_overflow(io), .wave_out_a(oa),
		.wave_out_b(ob), .wave_out_a_en(ea), .wave_out_b_en(eb));
	core_model core (.aclk(aclk), .aresetn(aresetn), .auto_ack(auto_ack), .irq_match_a(ia),
		.irq_match_b(ib), .irq_overflow(io), .ack_match_a(aa), .ack_match_b(ab),
		.ack_overflow(ao));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h00_0000, d};
		wstrb <= 4'hF;
		awv <= 1;
		wv <= 1;
		// hand-offs tracked locally: awv and wv still show their old value in this time step
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				awv <= 0;
				aw_done = 1'b1;
			end
			if (!w_done && wready === 1'b1) begin
				wv <= 0;
				w_done = 1'b1;
			end
		end
		bready <= 1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] idx);
		araddr <= {idx, 2'b00};
		arv <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arv <= 0;
		rready <= 1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 0;
	endtask
	// pulses are slow against the pin synchroniser so every edge is seen
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge aclk);
			pin <= 1;
			repeat (4) @(posedge aclk);
			pin <= 0;
		end
		repeat (6) @(posedge aclk);
	endtask
	task automatic test_done;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	logic [7:0] regs [7] = '{IDX_COUNTER, IDX_CONTROL_B, IDX_IRQ_MASK, IDX_CONTROL_A,
		IDX_COMPARE_A, IDX_COMPARE_B, IDX_IRQ_FLAGS};
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		foreach (regs[i]) begin
			rd(regs[i]);
			chk(rdata, 32'h0000_0000);
		end
		rd(8'h3F);
		chk({30'h0, rresp}, {30'h0, RESP_SLVERR});
		wr(8'h3F, 8'h00);
		chk({30'h0, bresp}, {30'h0, RESP_SLVERR});
		wr(IDX_CONTROL_B, 8'hF8);
		chk({30'h0, bresp}, {30'h0, RESP_OKAY});
		rd(IDX_CONTROL_B);
		chk(rdata, 32'h0000_0008);
		wr(IDX_CONTROL_B, 8'h00);
		wr(IDX_IRQ_MASK, 8'hFF);
		rd(IDX_IRQ_MASK);
		chk(rdata, 32'h0000_0007);
		$display("test registers done");
		for (int m = 3; m > 0; m--) begin
			wr(IDX_CONTROL_A, 8'(m * 80));
			wr(IDX_CONTROL_B, 8'hC0);
			repeat (3) @(posedge aclk);
			chk({30'h0, oa, ob}, (m == 2) ? 32'h0 : 32'h3);
			chk({30'h0, ea, eb}, 32'h0000_0003);
		end
		rd(IDX_IRQ_FLAGS);
		chk(rdata, 32'h0000_0000);
		wr(IDX_CONTROL_A, 8'h00);
		chk({30'h0, ea, eb}, 32'h0000_0000);
		$display("test force done");
		for (int s = 6; s < 8; s++) begin
			wr(IDX_COUNTER, 8'h00);
			wr(IDX_CONTROL_B, 8'(s));
			pulses(s - 3);
			wr(IDX_CONTROL_B, 8'h00);
			rd(IDX_COUNTER);
			chk(rdata, 32'(s - 3));
		end
		for (int k = 0; k < 3; k++) begin
			wr(IDX_COUNTER, 8'h00);
			wr(IDX_CONTROL_B, 8'(k + 1));
			repeat (40 << (3 * k)) @(posedge aclk);
			wr(IDX_CONTROL_B, 8'h00);
			rd(IDX_COUNTER);
			chk({31'h0, rdata >= 39 && rdata <= 45}, 32'h0000_0001);
		end
		$display("test clocks done");
		wr(IDX_IRQ_FLAGS, 8'h07);
		wr(IDX_COMPARE_A, 8'h10);
		wr(IDX_COMPARE_B, 8'h12);
		wr(IDX_COUNTER, 8'h0C);
		wr(IDX_CONTROL_B, 8'h01);
		repeat (300) @(posedge aclk);
		wr(IDX_CONTROL_B, 8'h00);
		rd(IDX_IRQ_FLAGS);
		chk(rdata, 32'h0000_0007);
		chk({29'h0, ib, ia, io}, 32'h0000_0000);
		gie <= 1;
		repeat (2) @(posedge aclk);
		chk({29'h0, ib, ia, io}, 32'h0000_0007);
		wr(IDX_IRQ_FLAGS, 8'h02);
		rd(IDX_IRQ_FLAGS);
		chk(rdata, 32'h0000_0005);
		chk({29'h0, ib, ia, io}, 32'h0000_0005);
		auto_ack <= 1;
		repeat (4) @(posedge aclk);
		rd(IDX_IRQ_FLAGS);
		chk(rdata, 32'h0000_0000);
		$display("test flags done");
		test_done;
	end
	initial begin
		#200000;
		miscompares++;
		test_done;
	end
endmodule
`default_nettype wire

//--- dv/timer8_sva.sv
`timescale 1ns/1ns
`default_nettype none
module timer8_sva (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic        global_irq_enable,
	input  wire logic        irq_match_a,
	input  wire logic        irq_match_b,
	input  wire logic        irq_overflow,
	input  wire logic        wave_out_a_en
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_read_answer;
		s_ar_taken |=> s_axi_rvalid;
	endproperty
	property p_rvalid_holds;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
	endproperty
	property p_bvalid_holds;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_rdata_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
	endproperty
	property p_irq_a_gate;
		irq_match_a |-> global_irq_enable;
	endproperty
	property p_irq_b_gate;
		irq_match_b |-> global_irq_enable;
	endproperty
	property p_irq_ov_gate;
		irq_overflow |-> global_irq_enable;
	endproperty
	// the pin enable follows the mode field, which only a register write moves
	property p_en_a_write;
		!$stable(wave_out_a_en) |-> $rose(s_axi_bvalid);
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	a_rvalid_holds: assert property (p_rvalid_holds) else $error("rvalid dropped");
	a_bvalid_holds: assert property (p_bvalid_holds) else $error("bvalid dropped");
	a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
	a_irq_a_gate: assert property (p_irq_a_gate) else $error("irq a ungated");
	a_irq_b_gate: assert property (p_irq_b_gate) else $error("irq b ungated");
	a_irq_ov_gate: assert property (p_irq_ov_gate) else $error("irq ov ungated");
	a_en_a_write: assert property (p_en_a_write) else $error("enable a moved alone");
endmodule
bind timer8_control_and_flags timer8_sva u_sva (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.global_irq_enable(global_irq_enable), .irq_match_a(irq_match_a),
	.irq_match_b(irq_match_b), .irq_overflow(irq_overflow), .wave_out_a_en(wave_out_a_en));
`default_nettype wire

//--- rtl/timer8_control_and_flags.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// R1 - force bit A in non-PWM mode makes an immediate channel A match on the output
// R2 - force bit B in non-PWM mode makes an immediate channel B match on the output
// R3 - forced matches set no flag, raise no interrupt, never clear the counter
// R4 - force bits are strobes only and always read as zero
// R5 - software keeps force bits zero when writing control B in PWM modes
// R6 - reserved bits of control B, mask and flag registers read zero
// R7 - clock select picks stop, undivided, or prescaler taps 8, 64, 256, 1024
// R8 - select 110 counts on pin falling edges, 111 on rising edges
// R9 - count pin edges clock the counter even when the pin is an output
// R10 - counter is directly readable and writable, resets to zero
// R11 - a counter write blocks compare matches on the next timer tick
// R12 - software avoids changing the running counter to not miss matches
// R13 - compare A is always compared with the counter; feeds flag, and pin A in non-PWM modes only
// R14 - compare B is always compared with the counter; feeds flag, and pin B in non-PWM modes only
// R15 - mask bits 2,1,0 gate flags with global enable into interrupt requests
// R16 - match B flag at bit 2 sets on counter equal compare B
// R17 - match A flag at bit 1 sets on counter equal compare A
// R18 - overflow flag at bit 0 sets at a point chosen by the wave mode
// R19 - a flag clears by hardware when its interrupt vector runs
// R20 - writing one to a flag clears it, zero leaves it
// R21 - wave mode is high bit in control B plus two low bits in control A
// R22 - non-PWM output modes: off, toggle, clear, set on match
// R23 - per-source acknowledge strobes clear the matching flag
module timer8_control_and_flags
(
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [timer8_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [timer8_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        external_count_pin,
	input  wire logic                        global_irq_enable,
	input  wire logic                        ack_match_a,
	input  wire logic                        ack_match_b,
	input  wire logic                        ack_overflow,
	output logic                             irq_match_a,
	output logic                             irq_match_b,
	output logic                             irq_overflow,
	output logic                             wave_out_a,
	output logic                             wave_out_b,
	output logic                             wave_out_a_en,
	output logic                             wave_out_b_en
);
	import timer8_pkg::*;

	function automatic logic [7:0] byte_index(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:2];
	endfunction

	function automatic logic is_pwm(input logic [2:0] m);
		return m[0];
	endfunction

	function automatic logic apply_mode(input logic [1:0] om, input logic cur);
		unique case (om)
			2'b01:   return ~cur;
			2'b10:   return 1'b0;
			2'b11:   return 1'b1;
			default: return cur;
		endcase
	endfunction

	logic [7:0] counter_value;
	logic [7:0] compare_value_a;
	logic [7:0] compare_value_b;
	logic [1:0] out_mode_a;
	logic [1:0] out_mode_b;
	logic [1:0] wave_mode_low_bits;
	logic       wave_mode_high_bit;
	logic [2:0] clock_source_select;
	logic [2:0] timer_irq_mask;
	logic [2:0] timer_irq_flags;
	logic [2:0] wave_mode;
	logic [9:0] prescale;
	logic       pin_sync1;
	logic       pin_sync2;
	logic       pin_prev;
	logic       tick;
	logic       block_match;
	logic       count_up;
	logic [7:0] top_value;
	logic       match_a;
	logic       match_b;
	logic       at_top;
	logic       ovf_event;
	logic       wave_a;
	logic       wave_b;

	// write path state
	logic                aw_held;
	logic                w_held;
	logic [ADDR_W-1:0]   aw_addr;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                wr_go;
	logic [7:0]          wr_idx;
	logic                wr_ok;
	logic [7:0]          wbyte;
	logic                wr_lane;

	assign wave_mode = {wave_mode_high_bit, wave_mode_low_bits}; // [R21]

	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign wr_go   = aw_held & w_held & ~s_axi_bvalid;
	assign wr_idx  = byte_index(aw_addr);
	assign wbyte   = w_data[7:0];
	assign wr_lane = w_strb[0];
	always_comb begin
		unique case (wr_idx)
			IDX_COUNTER, IDX_CONTROL_B, IDX_IRQ_MASK, IDX_CONTROL_A,
			IDX_COMPARE_A, IDX_COMPARE_B, IDX_IRQ_FLAGS: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// write strobes, qualified by byte lane 0 where the registers live
	logic wr_counter;
	logic wr_control_b;
	logic wr_control_a;
	logic wr_flags;
	assign wr_counter   = wr_go & wr_lane & (wr_idx == IDX_COUNTER);
	assign wr_control_b = wr_go & wr_lane & (wr_idx == IDX_CONTROL_B);
	assign wr_control_a = wr_go & wr_lane & (wr_idx == IDX_CONTROL_A);
	assign wr_flags     = wr_go & wr_lane & (wr_idx == IDX_IRQ_FLAGS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read path
	logic [7:0] rd_byte;
	logic       rd_ok;
	always_comb begin
		rd_byte = 8'h00;
		rd_ok   = 1'b1;
		unique case (byte_index(s_axi_araddr))
			IDX_COUNTER:   rd_byte = counter_value; // [R10]
			// force strobes and bits 5:4 read as zero
			IDX_CONTROL_B: rd_byte = {4'h0, wave_mode_high_bit, clock_source_select}; // [R4] [R6]
			IDX_CONTROL_A: rd_byte = {out_mode_a, out_mode_b, 2'b00, wave_mode_low_bits};
			IDX_COMPARE_A: rd_byte = compare_value_a;
			IDX_COMPARE_B: rd_byte = compare_value_b;
			IDX_IRQ_MASK:  rd_byte = {5'h00, timer_irq_mask}; // [R6]
			IDX_IRQ_FLAGS: rd_byte = {5'h00, timer_irq_flags}; // [R6]
			default:       rd_ok   = 1'b0;
		endcase
	end

	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wave_mode_high_bit  <= 1'b0;
			clock_source_select <= CS_STOP;
			wave_mode_low_bits  <= 2'b00;
			out_mode_a          <= 2'b00;
			out_mode_b          <= 2'b00;
			compare_value_a     <= RESET_BYTE;
			compare_value_b     <= RESET_BYTE;
			timer_irq_mask      <= 3'b000;
		end else begin
			if (wr_control_b) begin
				wave_mode_high_bit  <= wbyte[CB_WAVE_HI];
				clock_source_select <= wbyte[2:0];
			end
			if (wr_control_a) begin
				out_mode_a         <= wbyte[CA_OUT_A_LO+:2];
				out_mode_b         <= wbyte[CA_OUT_B_LO+:2];
				wave_mode_low_bits <= wbyte[1:0];
			end
			if (wr_go && wr_lane && wr_idx == IDX_COMPARE_A) compare_value_a <= wbyte;
			if (wr_go && wr_lane && wr_idx == IDX_COMPARE_B) compare_value_b <= wbyte;
			if (wr_go && wr_lane && wr_idx == IDX_IRQ_MASK) timer_irq_mask <= wbyte[2:0]; // [R15]
		end
	end

	// prescaler runs free; taps fire when the low bits wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) prescale <= '0;
		else prescale <= prescale + 10'd1;
	end

	// the pin is asynchronous; edge detect reads only the second stage onward
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_sync1 <= 1'b0;
			pin_sync2 <= 1'b0;
			pin_prev  <= 1'b0;
		end else begin
			pin_sync1 <= external_count_pin; // [R9]
			pin_sync2 <= pin_sync1;
			pin_prev  <= pin_sync2;
		end
	end

	always_comb begin
		unique case (clock_source_select) // [R7] [R8]
			CS_STOP:     tick = 1'b0;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = (prescale[2:0] == 3'h7);
			CS_DIV64:    tick = (prescale[5:0] == 6'h3F);
			CS_DIV256:   tick = (prescale[7:0] == 8'hFF);
			CS_DIV1024:  tick = (prescale == PRESCALE_WRAP);
			CS_EXT_FALL: tick = pin_prev & ~pin_sync2;
			CS_EXT_RISE: tick = ~pin_prev & pin_sync2;
		endcase
	end

	// counting: normal/fast up, ctc clears at compare a, phase correct up/down
	assign top_value = (wave_mode == 3'd2 || wave_mode[2]) ? compare_value_a : COUNT_MAX;
	assign at_top    = (counter_value == top_value);
	assign match_a   = tick & ~block_match & (counter_value == compare_value_a); // [R13] [R11]
	assign match_b   = tick & ~block_match & (counter_value == compare_value_b); // [R14] [R11]

	always_comb begin
		unique case (wave_mode) // [R18]
			3'd1, 3'd5: ovf_event = tick & ~count_up & (counter_value == COUNT_BOT + 8'd1);
			3'd7:       ovf_event = tick & at_top;
			default:    ovf_event = tick & (counter_value == COUNT_MAX); // [R21]
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_value <= RESET_BYTE;
			count_up      <= 1'b1;
			block_match   <= 1'b0;
		end else if (wr_counter) begin
			counter_value <= wbyte; // [R10]
			block_match   <= 1'b1; // [R11]
		end else if (tick) begin
			block_match <= 1'b0;
			if (is_pwm(wave_mode) && wave_mode != 3'd3 && wave_mode != 3'd7) begin
				if (count_up && at_top) begin
					count_up      <= 1'b0;
					counter_value <= counter_value - 8'd1;
				end else if (!count_up && counter_value == COUNT_BOT) begin
					count_up      <= 1'b1;
					counter_value <= counter_value + 8'd1;
				end else begin
					counter_value <= count_up ? counter_value + 8'd1 : counter_value - 8'd1;
				end
			end else if (at_top) begin
				counter_value <= COUNT_BOT;
			end else begin
				counter_value <= counter_value + 8'd1;
			end
		end
	end

	// flags: hardware set beats any clear in the same cycle
	logic [2:0] set_vec;
	logic [2:0] clr_vec;
	assign set_vec = {match_b, match_a, ovf_event}; // [R16] [R17] [R18] [R3]
	assign clr_vec = ({3{wr_flags}} & wbyte[2:0]) // [R20]
		| {ack_match_b, ack_match_a, ack_overflow}; // [R19] [R23]
	always_ff @(posedge aclk) begin
		if (!aresetn) timer_irq_flags <= 3'b000;
		else timer_irq_flags <= set_vec | (timer_irq_flags & ~clr_vec);
	end

	assign irq_match_b  = global_irq_enable & timer_irq_mask[BIT_MATCH_B] & timer_irq_flags[BIT_MATCH_B]; // [R15]
	assign irq_match_a  = global_irq_enable & timer_irq_mask[BIT_MATCH_A] & timer_irq_flags[BIT_MATCH_A]; // [R15]
	assign irq_overflow = global_irq_enable & timer_irq_mask[BIT_OVERFLOW] & timer_irq_flags[BIT_OVERFLOW]; // [R15]

	// waveform: non-PWM compare actions only; force strobes use the same action path
	logic force_a;
	logic force_b;
	assign force_a = wr_control_b & wbyte[CB_FORCE_A] & ~is_pwm(wave_mode); // [R1] [R4]
	assign force_b = wr_control_b & wbyte[CB_FORCE_B] & ~is_pwm(wave_mode); // [R2] [R4]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wave_a <= 1'b0;
			wave_b <= 1'b0;
		end else begin
			if (!is_pwm(wave_mode) && (match_a || force_a)) wave_a <= apply_mode(out_mode_a, wave_a); // [R22] [R1]
			if (!is_pwm(wave_mode) && (match_b || force_b)) wave_b <= apply_mode(out_mode_b, wave_b); // [R22] [R2]
		end
	end
	assign wave_out_a    = wave_a;
	assign wave_out_b    = wave_b;
	assign wave_out_a_en = (out_mode_a != 2'b00);
	assign wave_out_b_en = (out_mode_b != 2'b00);
endmodule
`default_nettype wire
